// >>> rtl/fsg_guard.sv
// flash self-program access guard with wishbone register slave
`timescale 1ns/100ps
`default_nettype none

module fsg_guard
	import fsg_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// core instruction stream
	input wire logic [ADDR_W-1:0] fetch_addr_i,
	input wire logic ivec_boot_i,
	input wire logic spm_i,
	input wire logic [ADDR_W-1:0] spm_addr_i,
	input wire logic [7:0] spm_data_i,
	input wire logic lpm_i,
	input wire logic [ADDR_W-1:0] lpm_addr_i,
	// flash controller
	input wire logic prog_done_i,
	output logic spm_start_o,
	output logic [1:0] spm_op_o,
	output logic [ADDR_W-1:0] spm_page_o,
	// core controls
	output logic lpm_ok_o,
	output logic lpm_deny_o,
	output logic halt_o,
	output logic rww_busy_o,
	output logic irq_block_o
);

	// boot section start for the fuse setting
	function automatic logic [14:0] boot_start(input logic [1:0] fz);
		logic [14:0] sz;
		sz = BOOT_MIN_WORDS << (2'h3 - fz);
		if (sz > HALTING_SECTION_WORDS)
		begin
			sz = HALTING_SECTION_WORDS;
		end
		boot_start = FLASH_WORDS - sz;
	endfunction

	// address lies in the boot loader section
	function automatic logic in_boot(input logic [ADDR_W-1:0] a, input logic [1:0] fz);
		in_boot = {1'b0, a} >= boot_start(fz);
	endfunction

	// address lies in the halting section
	function automatic logic in_halting_section(input logic [ADDR_W-1:0] a);
		in_halting_section = {1'b0, a} >= (FLASH_WORDS - HALTING_SECTION_WORDS);
	endfunction

	// control pattern that may arm the store window; anything else is dropped
	function automatic logic cmd_ok(input logic [4:0] c);
		cmd_ok = (c == CMD_FILL) | (c == CMD_ERASE) | (c == CMD_WRITE) |
			(c == CMD_LOCKSET) | (c == CMD_REEN);
	endfunction

	fsg_state_t state_q;
	fsg_state_t state_d;
	logic [4:0] cmd_q;
	logic [2:0] win_q;
	logic busy_flag_q;
	logic halt_q;
	logic ign_q;
	logic [3:0] lock_q;
	logic [1:0] boot_size_fuses_q;
	logic ack_q;
	logic [31:0] rdat_q;
	logic start_q;
	logic [1:0] op_q;
	logic [ADDR_W-1:0] page_q;
	logic lpm_ok_q;
	logic lpm_deny_q;
	logic irq_blk_q;
	logic wb_req;
	logic wb_wr;
	logic ctrl_arm;
	logic fetch_boot;
	logic spm_take;
	logic spm_from_app;
	logic tgt_boot;
	logic tgt_halting_section;
	logic wr_locked;
	logic prog_go;
	logic lock_go;
	logic reen_go;
	logic [1:0] app_lk;
	logic [1:0] boot_lk;

	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
	// arming and latching share one decode so a bad pattern cannot open the window
	assign ctrl_arm = (state_q == ST_IDLE) & wb_wr & (wb_adr_i == OFS_CTRL) &
		cmd_ok(wb_dat_i[4:0]);
	assign app_lk = lock_q[LOCK_APP +: 2];
	assign boot_lk = lock_q[LOCK_BOOT +: 2];

	assign fetch_boot = in_boot(fetch_addr_i, boot_size_fuses_q);
	assign spm_take = (state_q == ST_ARMED) & spm_i;
	assign spm_from_app = ~fetch_boot;

	assign tgt_boot = in_boot(spm_addr_i, boot_size_fuses_q);
	assign tgt_halting_section = in_halting_section(spm_addr_i);

	assign wr_locked = tgt_boot ? ~boot_lk[0] : ~app_lk[0];

	// boot code may target any page whose section is not write-locked
	assign prog_go = spm_take & ~spm_from_app & ~wr_locked &
		((cmd_q == CMD_ERASE) | (cmd_q == CMD_WRITE));
	assign lock_go = spm_take & ~spm_from_app & (cmd_q == CMD_LOCKSET);
	assign reen_go = spm_take & ~spm_from_app & (cmd_q == CMD_REEN);

	// sequencer next state
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (ctrl_arm)
				begin
					state_d = ST_ARMED;
				end
			end
			ST_ARMED:
			begin
				if (prog_go)
				begin
					state_d = ST_BUSY;
				end
				else if (spm_take | (win_q == 3'h1))
				begin
					state_d = ST_IDLE;
				end
			end
			ST_BUSY:
			begin
				if (prog_done_i)
				begin
					state_d = ST_IDLE;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q <= ST_IDLE;
		end
		else if (ce_i)
		begin
			state_q <= state_d;
		end
	end

	// command latch and enable window; bad patterns have no effect
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cmd_q <= 5'h00;
			win_q <= 3'h0;
		end
		else if (ce_i)
		begin
			if (ctrl_arm)
			begin
				cmd_q <= wb_dat_i[4:0];
				win_q <= SPM_WINDOW;
			end
			else if (state_d == ST_IDLE)
			begin
				cmd_q <= 5'h00;
				win_q <= 3'h0;
			end
			else if (state_q == ST_ARMED)
			begin
				win_q <= win_q - 3'h1;
			end
		end
	end

	// section busy flag; a new block beats a clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			busy_flag_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (prog_go & ~tgt_halting_section)
			begin
				busy_flag_q <= 1'b1;
			end
			else if (reen_go)
			begin
				busy_flag_q <= 1'b0;
			end
		end
	end

	// core halt for the whole halting-section operation
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			halt_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (prog_go & tgt_halting_section)
			begin
				halt_q <= 1'b1;
			end
			else if (prog_done_i)
			begin
				halt_q <= 1'b0;
			end
		end
	end

	// sticky note of a store ignored from application code
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ign_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (spm_take & spm_from_app)
			begin
				ign_q <= 1'b1;
			end
			else if (wb_wr & (wb_adr_i == OFS_STAT) & wb_dat_i[STAT_IGN])
			begin
				ign_q <= 1'b0;
			end
		end
	end

	// lock bits only move toward programmed, chip erase restores them
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			lock_q <= LOCK_RST;
		end
		else if (ce_i)
		begin
			if (wb_wr & (wb_adr_i == OFS_CFG) & wb_dat_i[CFG_CHIPERASE])
			begin
				lock_q <= LOCK_RST;
			end
			else if (lock_go)
			begin
				lock_q <= lock_q & {spm_data_i[LDAT_BOOT +: 2], spm_data_i[LDAT_APP +: 2]};
			end
			else if (wb_wr & (wb_adr_i == OFS_LOCK))
			begin
				lock_q <= lock_q & wb_dat_i[3:0];
			end
		end
	end

	// boot size fuses, set by the programming interface only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			boot_size_fuses_q <= BOOT_SIZE_FUSES_RST;
		end
		else if (ce_i)
		begin
			if (wb_wr & (wb_adr_i == OFS_CFG))
			begin
				boot_size_fuses_q <= wb_dat_i[CFG_BOOT_SIZE_FUSES +: 2];
			end
		end
	end

	// operation start toward the flash controller
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			start_q <= 1'b0;
			op_q <= OP_FILL;
			page_q <= '0;
		end
		else if (ce_i)
		begin
			start_q <= prog_go | (spm_take & ~spm_from_app & (cmd_q == CMD_FILL));
			if (spm_take & ~spm_from_app)
			begin
				op_q <= (cmd_q == CMD_ERASE) ? OP_ERASE :
					(cmd_q == CMD_WRITE) ? OP_WRITE : OP_FILL;
				page_q <= spm_addr_i;
			end
		end
	end

	// load-program read permission
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			lpm_ok_q <= 1'b0;
			lpm_deny_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (lpm_i & ((~in_boot(lpm_addr_i, boot_size_fuses_q) & fetch_boot & ~app_lk[1]) |
				(in_boot(lpm_addr_i, boot_size_fuses_q) & ~fetch_boot & ~boot_lk[1])))
			begin
				lpm_ok_q <= 1'b0;
				lpm_deny_q <= 1'b1;
			end
			else
			begin
				lpm_ok_q <= lpm_i;
				lpm_deny_q <= 1'b0;
			end
		end
	end

	// interrupt gating by lock and vector placement
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_blk_q <= 1'b0;
		end
		else if (ce_i)
		begin
			irq_blk_q <= (~fetch_boot & ~app_lk[1] & ivec_boot_i) |
				(fetch_boot & ~boot_lk[1] & ~ivec_boot_i);
		end
	end

	// wishbone answer one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			ack_q <= wb_req;
			rdat_q <= 32'h0000_0000;
			if (wb_req & ~wb_we_i)
			begin
				case (wb_adr_i)
					OFS_CTRL:
					begin
						rdat_q[4:0] <= (state_q == ST_IDLE) ? 5'h00 : cmd_q;
						rdat_q[CTRL_BUSY] <= busy_flag_q;
					end
					OFS_STAT:
					begin
						rdat_q[STAT_BUSY] <= busy_flag_q;
						rdat_q[STAT_HALT] <= halt_q;
						rdat_q[STAT_PROG] <= state_q == ST_BUSY;
						rdat_q[STAT_IGN] <= ign_q;
					end
					OFS_LOCK:
					begin
						rdat_q[3:0] <= lock_q;
					end
					OFS_CFG:
					begin
						rdat_q[CFG_BOOT_SIZE_FUSES +: 2] <= boot_size_fuses_q;
					end
					default:
					begin
						rdat_q <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign spm_start_o = start_q;
	assign spm_op_o = op_q;
	assign spm_page_o = page_q;
	assign lpm_ok_o = lpm_ok_q;
	assign lpm_deny_o = lpm_deny_q;
	assign halt_o = halt_q;
	assign rww_busy_o = busy_flag_q;
	assign irq_block_o = irq_blk_q;

endmodule // fsg_guard

`default_nettype wire

// >>> rtl/fsg_pkg.sv
// shared constants for the flash self-program guard
package fsg_pkg;
	// flash geometry in 16-bit words
	localparam int ADDR_W = 14;
	localparam int PAGE_LSB = 6;
	localparam logic [14:0] FLASH_WORDS = 15'h4000;
	localparam logic [14:0] HALTING_SECTION_WORDS = 15'h0800;
	localparam logic [14:0] BOOT_MIN_WORDS = 15'h0100;
	// register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STAT = 4'h4;
	localparam logic [3:0] OFS_LOCK = 4'h8;
	localparam logic [3:0] OFS_CFG = 4'hc;
	// control register fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_ERASE = 1;
	localparam int CTRL_WRITE = 2;
	localparam int CTRL_LOCKSET = 3;
	localparam int CTRL_REEN = 4;
	localparam int CTRL_BUSY = 6;
	// accepted command patterns in the low five bits
	localparam logic [4:0] CMD_FILL = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_LOCKSET = 5'h09;
	localparam logic [4:0] CMD_REEN = 5'h11;
	// status register fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_HALT = 1;
	localparam int STAT_PROG = 2;
	localparam int STAT_IGN = 3;
	// lock register fields, each field is {high,low}, 1 = unprogrammed
	localparam int LOCK_APP = 0;
	localparam int LOCK_BOOT = 2;
	localparam logic [3:0] LOCK_RST = 4'hf;
	// lock data positions in the low working register
	localparam int LDAT_APP = 2;
	localparam int LDAT_BOOT = 4;
	// config register fields
	localparam int CFG_BOOT_SIZE_FUSES = 0;
	localparam int CFG_CHIPERASE = 7;
	localparam logic [1:0] BOOT_SIZE_FUSES_RST = 2'h0;
	// store-program enable window
	localparam logic [2:0] SPM_WINDOW = 3'h4;
	// guard sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ARMED = 3'b010,
		ST_BUSY = 3'b100
	} fsg_state_t;
	// operation codes reported to the flash controller
	localparam logic [1:0] OP_FILL = 2'h0;
	localparam logic [1:0] OP_ERASE = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h2;
endpackage

// >>> verification/fsg_guard_properties.sv
// assertions on the guard's ports
`timescale 1ns/100ps
`default_nettype none
module fsg_guard_properties
	import fsg_pkg::*;
(
	// clock, reset, bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// core and flash
	input wire logic [ADDR_W-1:0] fetch_addr_i,
	input wire logic spm_i,
	input wire logic lpm_i,
	input wire logic prog_done_i,
	input wire logic spm_start_o,
	input wire logic [1:0] spm_op_o,
	input wire logic [ADDR_W-1:0] spm_page_o,
	input wire logic lpm_ok_o,
	input wire logic lpm_deny_o,
	input wire logic halt_o
);
	// a frozen clock enable stalls everything, so checks pause with it
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	app_store_a: assert property (spm_i && fetch_addr_i < 14'h3800 |=> !spm_start_o)
		else $error("store from application started");
	start_cause_a: assert property (spm_start_o |-> $past(spm_i) && $past(fetch_addr_i) >= 14'h3800)
		else $error("start without boot store");
	halt_target_a: assert property (spm_start_o && spm_op_o != OP_FILL |-> halt_o == (spm_page_o >= 14'h3800))
		else $error("halt wrong for page");
	halt_hold_a: assert property (halt_o && !prog_done_i |=> halt_o)
		else $error("halt dropped early");
	halt_end_a: assert property (halt_o && prog_done_i |=> !halt_o)
		else $error("halt stuck");
	lpm_answer_a: assert property (lpm_i |=> lpm_ok_o != lpm_deny_o)
		else $error("load answer wrong");
endmodule // fsg_guard_properties
bind fsg_guard fsg_guard_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fetch_addr_i(fetch_addr_i),
	.spm_i(spm_i), .lpm_i(lpm_i), .prog_done_i(prog_done_i), .spm_start_o(spm_start_o),
	.spm_op_o(spm_op_o), .spm_page_o(spm_page_o), .lpm_ok_o(lpm_ok_o),
	.lpm_deny_o(lpm_deny_o), .halt_o(halt_o));
`default_nettype wire

// >>> verification/fsg_flash_model.sv
// flash controller stand-in: done pulse after a settable delay
`timescale 1ns/100ps
`default_nettype none
module fsg_flash_model
	import fsg_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// guard side
	input wire logic spm_start_i,
	input wire logic [1:0] spm_op_i,
	input wire logic [3:0] delay_i,
	output logic prog_done_o
);
	logic [3:0] cnt_q;
	logic run_q;
	// done pulse ends erase or write
	always_ff @(posedge clk_i)
	begin
		prog_done_o <= 1'h0;
		if (rst_i)
			run_q <= 1'h0;
		else if (spm_start_i && spm_op_i != OP_FILL)
		begin
			run_q <= 1'h1;
			cnt_q <= delay_i;
		end
		else if (run_q && cnt_q == 4'h0)
		begin
			run_q <= 1'h0;
			prog_done_o <= 1'h1;
		end
		else if (run_q)
			cnt_q <= cnt_q - 4'h1;
	end
endmodule // fsg_flash_model
`default_nettype wire

// >>> verification/fsg_guard_tb.sv
// self-checking bench for the flash self-program guard
`timescale 1ns/100ps
`default_nettype none
module fsg_guard_tb;
	import fsg_pkg::*;
	logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ivb = 1'h0, ce = 1'h1;
	logic spm = 1'h0, lpm = 1'h0, ack, st, ok, dny, halt, busy, irqb, dn;
	logic [3:0] adr = 4'h0, dly = 4'h1;
	logic [31:0] wd = 32'h0, rd, d;
	logic [13:0] fa = 14'h3f80, sa = 14'h0, la = 14'h0, pg;
	logic [7:0] sd = 8'hff;
	logic [1:0] op;
	int failures = 0, n_checks = 0, ticks = 0;
	always #2.5 clk = ~clk;
	fsg_guard uut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd),
		.wb_ack_o(ack), .fetch_addr_i(fa), .ivec_boot_i(ivb), .spm_i(spm), .spm_addr_i(sa),
		.spm_data_i(sd), .lpm_i(lpm), .lpm_addr_i(la), .prog_done_i(dn), .spm_start_o(st),
		.spm_op_o(op), .spm_page_o(pg), .lpm_ok_o(ok), .lpm_deny_o(dny), .halt_o(halt),
		.rww_busy_o(busy), .irq_block_o(irqb));
	fsg_flash_model flash (.clk_i(clk), .rst_i(rst), .spm_start_i(st), .spm_op_i(op),
		.delay_i(dly), .prog_done_o(dn));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wd <= v;
		do
			@(posedge clk);
		while (ack !== 1'h1);
		d = rd;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	// store right after the control write, well inside the window
	task automatic cmd(input logic [4:0] c, input logic [13:0] f, input logic [13:0] a,
		input logic [7:0] v, input logic e);
		wb(1'h1, OFS_CTRL, {27'h0, c});
		fa <= f;
		sa <= a;
		sd <= v;
		spm <= 1'h1;
		@(posedge clk);
		spm <= 1'h0;
		#1;
		chk("start", e, st);
	endtask
	task automatic ld(input logic [13:0] f, input logic [13:0] a, input logic e);
		@(posedge clk);
		fa <= f;
		la <= a;
		lpm <= 1'h1;
		@(posedge clk);
		lpm <= 1'h0;
		#1;
		chk("ok", e, ok);
		chk("deny", !e, dny);
	endtask
	task automatic irq(input logic v, input logic [13:0] f, input logic e);
		@(posedge clk);
		ivb <= v;
		fa <= f;
		repeat (2) @(posedge clk);
		#1;
		chk("irq", e, irqb);
	endtask
	// fetch stays in the boot code while programming runs
	task automatic fin_prog;
		do
			@(posedge clk);
		while (dn !== 1'h1);
		#1;
		chk("halt", 32'h0, halt);
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		ticks++;
		if (ticks == 5000)
		begin
			failures++;
			finish_test;
		end
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		ivb <= 1'h1;
		wb(1'h0, OFS_LOCK, 32'h0);
		chk("lock", {28'h0, LOCK_RST}, d);
		wb(1'h0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, d);
		cmd(CMD_ERASE, 14'h0100, 14'h0040, 8'hff, 1'h0);
		wb(1'h0, OFS_STAT, 32'h0);
		chk("stat", 32'h8, d);
		wb(1'h1, OFS_STAT, 32'h8);
		$display("test app store done");
		dly <= 4'hf;
		cmd(CMD_ERASE, 14'h3f80, 14'h0040, 8'hff, 1'h1);
		chk("halt", 32'h0, halt);
		chk("page", 32'h40, pg);
		chk("op", {30'h0, OP_ERASE}, op);
		wb(1'h0, OFS_STAT, 32'h0);
		chk("stat", 32'h5, d);
		fin_prog;
		wb(1'h0, OFS_STAT, 32'h0);
		chk("stat", 32'h1, d);
		wb(1'h0, OFS_CTRL, 32'h0);
		chk("ctrl", 32'h40, d);
		// flag cleared before the busy section is read
		cmd(CMD_REEN, 14'h3f80, 14'h0, 8'hff, 1'h0);
		chk("busy", 32'h0, busy);
		dly <= 4'h1;
		cmd(CMD_WRITE, 14'h3f80, 14'h3900, 8'hff, 1'h1);
		chk("halt", 32'h1, halt);
		fin_prog;
		$display("test erase and write done");
		cmd(CMD_LOCKSET, 14'h3f80, 14'h0, 8'hfb, 1'h0);
		wb(1'h0, OFS_LOCK, 32'h0);
		chk("lock", 32'he, d);
		cmd(CMD_ERASE, 14'h3f80, 14'h0040, 8'hff, 1'h0);
		cmd(CMD_ERASE, 14'h3f80, 14'h3f40, 8'hff, 1'h1);
		fin_prog;
		cmd(CMD_LOCKSET, 14'h3f80, 14'h0, 8'hd3, 1'h0);
		wb(1'h0, OFS_LOCK, 32'h0);
		chk("lock", 32'h4, d);
		ld(14'h3f80, 14'h0010, 1'h0);
		ld(14'h0100, 14'h0010, 1'h1);
		ld(14'h0100, 14'h3f90, 1'h0);
		ld(14'h3f80, 14'h3f90, 1'h1);
		irq(1'h1, 14'h0100, 1'h1);
		irq(1'h0, 14'h3f80, 1'h1);
		irq(1'h1, 14'h3f80, 1'h0);
		$display("test locks done");
		wb(1'h1, OFS_CFG, 32'h83);
		wb(1'h0, OFS_LOCK, 32'h0);
		chk("lock", 32'hf, d);
		cmd(CMD_ERASE, 14'h3800, 14'h0040, 8'hff, 1'h0);
		wb(1'h0, OFS_CFG, 32'h0);
		chk("cfg", 32'h3, d);
		// a refused pattern must leave the guard idle for the next command
		wb(1'h1, OFS_CTRL, 32'h7);
		wb(1'h0, OFS_CTRL, 32'h0);
		chk("ctrl", 32'h0, d);
		cmd(CMD_ERASE, 14'h3f00, 14'h0040, 8'hff, 1'h1);
		fin_prog;
		cmd(CMD_FILL, 14'h3f00, 14'h0045, 8'hff, 1'h1);
		chk("op", {30'h0, OP_FILL}, op);
		chk("page", 32'h45, pg);
		// clock enable low freezes the load answer
		@(posedge clk);
		ce <= 1'h0;
		la <= 14'h0010;
		lpm <= 1'h1;
		@(posedge clk);
		lpm <= 1'h0;
		#1;
		chk("frozen", 32'h0, ok);
		@(posedge clk);
		ce <= 1'h1;
		$display("test boot size done");
		finish_test;
	end
endmodule // fsg_guard_tb
`default_nettype wire
